// file: src/pic_pkg.sv
// package for the priority interrupt controller: sizes, levels, reset values
// assumes one system clock domain shared by controller and core
package pic_pkg;
  localparam int NUM_SRC = 8;
  localparam int IDX_W   = 3;

  // two-bit level code per source; 0 means disabled except for sources in FORCE_TOP_MASK
  typedef logic [1:0] pic_level_t;
  localparam pic_level_t LVL_OFF = 2'h0;
  localparam pic_level_t LVL_1   = 2'h1;
  localparam pic_level_t LVL_2   = 2'h2;
  localparam pic_level_t LVL_3   = 2'h3;

  // sources forced to the top level whatever software programs
  localparam logic [7:0] FORCE_TOP_MASK = 8'h0f;

  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic       GIE_RST  = 1'b0;
  localparam logic [7:0] IRQ_RST  = 8'h00;
endpackage

// file: src/pic_core_if.sv
// interface joining the interrupt controller and the processor core end
// assumes both ends run on core_clk; the testbench instantiates it
`timescale 1ns/100ps
interface pic_core_if;
  logic                       svcReq;
  logic [pic_pkg::IDX_W-1:0]  svcIdx;
  logic                       svcAck;
  logic [pic_pkg::IDX_W-1:0]  ackIdx;
  logic                       gieSet;
  logic                       gieClr;
  logic                       disInstr;
  logic                       trapInstr;
  logic                       pendWrEn;
  logic [pic_pkg::NUM_SRC-1:0] pendWrData;
  logic                       gieState;
  logic [pic_pkg::NUM_SRC-1:0] pendState;

  modport ctrl (
    output svcReq, svcIdx, gieState, pendState,
    input  svcAck, ackIdx, gieSet, gieClr, disInstr, trapInstr, pendWrEn, pendWrData
  );
  modport core (
    input  svcReq, svcIdx, gieState, pendState,
    output svcAck, ackIdx, gieSet, gieClr, disInstr, trapInstr, pendWrEn, pendWrData
  );
endinterface

// file: src/pic_ctrl.sv
// priority interrupt controller: pending latch, three-level ranking, global enable
// assumes request pulses come from logic on core_clk, one cycle wide
// assumes trap strobes come from the same clock domain, so none is synchronised
// limitation: one request is offered at a time; levels do not nest
//
// Contract
// - writing one sets global enable
// - disable instruction clears global enable
// - acknowledge clears global enable
// - writing zero clears global enable
// - reset or trap leaves interrupts disabled
// - illegal/oscillator fault traps clear global enable
// - three levels, higher level always wins
// - fixed source order within a level
// - reset, watchdog, fault traps forced top
// - sources pulse for exactly one cycle
// - acknowledge clears matching pending bit
// - software zero write clears pending bit
// - avoid read-modify-write clears, requests lost
`timescale 1ns/100ps
module pic_ctrl (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic [pic_pkg::NUM_SRC-1:0] srcPulse,
  input  wire logic [pic_pkg::NUM_SRC-1:0] srcEnable,
  input  wire logic [2*pic_pkg::NUM_SRC-1:0] srcLevel,
  input  wire logic                        illegalTrap,
  input  wire logic                        primOscTrap,
  input  wire logic                        wdtOscTrap,
  pic_core_if.ctrl                         cif
);

  ////////////////////////////////////////////////////////////////////////
  // pending requests
  logic [pic_pkg::NUM_SRC-1:0] pend_reg;
  logic [pic_pkg::NUM_SRC-1:0] pend_next;

  // global enable
  logic                        gie_reg;
  logic                        gie_next;
  logic                        gieKill;

  // service request towards the core
  logic                        req_reg;
  logic                        req_next;
  logic [pic_pkg::IDX_W-1:0]   idx_reg;
  logic [pic_pkg::IDX_W-1:0]   idx_next;

  // candidates per level, after forcing and enables
  logic [pic_pkg::NUM_SRC-1:0] lvl3Mask;
  logic [pic_pkg::NUM_SRC-1:0] lvl2Mask;
  logic [pic_pkg::NUM_SRC-1:0] lvl1Mask;
  logic                        candAny;

  ////////////////////////////////////////////////////////////////////////
  // effective level of one source, top level forced for fault sources
  function automatic pic_pkg::pic_level_t effLevel(
      input int                            i,
      input logic [2*pic_pkg::NUM_SRC-1:0] lv);
    // forced sources win even with level code 0 programmed
    if (pic_pkg::FORCE_TOP_MASK[i]) begin
      effLevel = pic_pkg::LVL_3;
    end else begin
      effLevel = lv[2*i +: 2];
    end
  endfunction

  // pending, enabled sources whose effective level equals want
  function automatic logic [pic_pkg::NUM_SRC-1:0] levelMask(
      input pic_pkg::pic_level_t           want,
      input logic [pic_pkg::NUM_SRC-1:0]   pend,
      input logic [pic_pkg::NUM_SRC-1:0]   en,
      input logic [2*pic_pkg::NUM_SRC-1:0] lv);
    levelMask = '0;
    for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
      if (pend[i] && en[i] && effLevel(i, lv) == want) begin
        levelMask[i] = 1'b1;
      end
    end
  endfunction

  // fixed order inside a level: the lowest index wins
  function automatic logic [pic_pkg::IDX_W-1:0] lowestIdx(
      input logic [pic_pkg::NUM_SRC-1:0] m);
    lowestIdx = '0;
    // scan downwards so the last hit is the lowest index
    for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        lowestIdx = i[pic_pkg::IDX_W-1:0];
      end
    end
  endfunction

  // one-hot mask of a source index
  function automatic logic [pic_pkg::NUM_SRC-1:0] idxMask(
      input logic [pic_pkg::IDX_W-1:0] idx);
    idxMask      = '0;
    idxMask[idx] = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pending latch
  always_comb begin
    logic [pic_pkg::NUM_SRC-1:0] ackMask;
    logic [pic_pkg::NUM_SRC-1:0] wrClr;
    ackMask = '0;
    wrClr   = '0;
    if (cif.svcAck) begin
      ackMask = idxMask(cif.ackIdx);
    end
    // only zero bits clear, so a whole-mask write keeps the rest
    if (cif.pendWrEn) begin
      wrClr = ~cif.pendWrData;
    end
    // a pulse in the clearing cycle survives: set wins
    pend_next = (pend_reg & ~ackMask & ~wrClr) | srcPulse;
  end

  // latches even while disabled, so nothing is missed
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_reg <= pic_pkg::PEND_RST;
    end else begin
      pend_reg <= pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // global enable: every disabling source beats a same-cycle enable
  always_comb begin
    gieKill = 1'b0;
    if (cif.gieClr) begin
      gieKill = 1'b1;
    end
    if (cif.disInstr) begin
      gieKill = 1'b1;
    end
    if (cif.svcAck) begin
      gieKill = 1'b1;
    end
    if (cif.trapInstr) begin
      gieKill = 1'b1;
    end
    if (illegalTrap || primOscTrap || wdtOscTrap) begin
      gieKill = 1'b1;
    end
    // enable only when no disabling source fires
    gie_next = gie_reg;
    if (gieKill) begin
      gie_next = 1'b0;
    end else if (cif.gieSet) begin
      gie_next = 1'b1;
    end
  end

  // reset leaves interrupts off until software enables them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gie_reg <= pic_pkg::GIE_RST;
    end else begin
      gie_reg <= gie_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ranking: candidates split by effective level
  always_comb begin
    // level code 0 matches no level, so an unforced source with it never wins
    lvl3Mask = levelMask(pic_pkg::LVL_3, pend_reg, srcEnable, srcLevel);
    lvl2Mask = levelMask(pic_pkg::LVL_2, pend_reg, srcEnable, srcLevel);
    lvl1Mask = levelMask(pic_pkg::LVL_1, pend_reg, srcEnable, srcLevel);
    candAny  = |{lvl3Mask, lvl2Mask, lvl1Mask};
  end

  // higher level always wins; index holds while nothing is pending
  always_comb begin
    idx_next = idx_reg;
    if (|lvl3Mask) begin
      idx_next = lowestIdx(lvl3Mask);
    end else if (|lvl2Mask) begin
      idx_next = lowestIdx(lvl2Mask);
    end else if (|lvl1Mask) begin
      idx_next = lowestIdx(lvl1Mask);
    end
    // request drops the cycle after acknowledge to avoid a double take
    req_next = gie_reg && !cif.svcAck && candAny;
  end

  // reset index is harmless while the request is low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_reg <= 1'b0;
      idx_reg <= '0;
    end else begin
      req_reg <= req_next;
      idx_reg <= idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, no logic after the registers
  assign cif.svcReq    = req_reg;
  assign cif.svcIdx    = idx_reg;
  assign cif.gieState  = gie_reg;
  assign cif.pendState = pend_reg;

endmodule

// file: src/pic_core_end.sv
// processor-core end: turns core-side strobes into interface pulses, acks requests
// assumes user strobes come from logic on core_clk
`timescale 1ns/100ps
module pic_core_end (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        userGieSet,
  input  wire logic                        userGieClr,
  input  wire logic                        userDis,
  input  wire logic                        userTrap,
  input  wire logic                        userPendWr,
  input  wire logic [pic_pkg::NUM_SRC-1:0] userPendData,
  input  wire logic                        userAutoAck,
  output logic                             svcTaken,
  output logic [pic_pkg::IDX_W-1:0]        svcTakenIdx,
  pic_core_if.core                         cif
);

  ////////////////////////////////////////////////////////////////////////
  logic                        ack_reg;
  logic                        ack_next;
  logic [pic_pkg::IDX_W-1:0]   ackIdx_reg;
  logic [pic_pkg::IDX_W-1:0]   ackIdx_next;
  logic [4:0]                  strb_reg;
  logic [4:0]                  strb_next;
  logic [pic_pkg::NUM_SRC-1:0] wd_reg;
  logic [pic_pkg::NUM_SRC-1:0] wd_next;

  always_comb begin
    // one ack per request; waiting a cycle lets the request drop first
    ack_next    = userAutoAck && cif.svcReq && !ack_reg;
    ackIdx_next = cif.svcIdx;
    strb_next   = {userPendWr, userTrap, userDis, userGieClr, userGieSet};
    // write whole mask at once
    wd_next     = userPendData;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_reg    <= 1'b0;
      ackIdx_reg <= '0;
      strb_reg   <= '0;
      wd_reg     <= pic_pkg::IRQ_RST;
    end else begin
      ack_reg    <= ack_next;
      ackIdx_reg <= ackIdx_next;
      strb_reg   <= strb_next;
      wd_reg     <= wd_next;
    end
  end

  assign cif.svcAck     = ack_reg;
  assign cif.ackIdx     = ackIdx_reg;
  assign cif.gieSet     = strb_reg[0];
  assign cif.gieClr     = strb_reg[1];
  assign cif.disInstr   = strb_reg[2];
  assign cif.trapInstr  = strb_reg[3];
  assign cif.pendWrEn   = strb_reg[4];
  assign cif.pendWrData = wd_reg;
  assign svcTaken       = ack_reg;
  assign svcTakenIdx    = ackIdx_reg;

endmodule

// file: testbench/pic_chk.sv
// checker: interface-level assertions for the controller and core end
// assumes one core_clk domain, instantiated beside the interface
`timescale 1ns/100ps
module pic_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       svcReq,
  input wire logic       svcAck,
  input wire logic [2:0] ackIdx,
  input wire logic       gieSet,
  input wire logic       gieClr,
  input wire logic       disInstr,
  input wire logic       trapInstr,
  input wire logic       pendWrEn,
  input wire logic [7:0] pendWrData,
  input wire logic       gieState,
  input wire logic [7:0] pendState
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // hardware traps are not visible here, so set is only checked against core-side clears
  a_gie_set_on: assert property (gieSet && !(gieClr || disInstr || trapInstr || svcAck) |=> gieState)
    else $error("gie not set");
  a_dis_clears: assert property (disInstr |=> !gieState)
    else $error("gie kept after disable");
  a_ack_clears_gie: assert property (svcAck |=> !gieState)
    else $error("gie kept after ack");
  a_zero_clears_gie: assert property (gieClr |=> !gieState)
    else $error("gie kept after clear");
  a_trap_clears: assert property (trapInstr |=> !gieState)
    else $error("gie kept after trap");
  a_ack_clears_pend: assert property (svcAck |=> !pendState[$past(ackIdx)])
    else $error("pending kept after ack");
  a_write_clears_pend: assert property (pendWrEn |=> (pendState & ~$past(pendWrData)) == 8'h00)
    else $error("pending kept after write");
  a_no_req_off: assert property (!gieState && !$past(gieState) |-> !svcReq)
    else $error("request while disabled");
  c_ack: cover property (svcAck);
  c_write: cover property (pendWrEn);
  c_set_req: cover property (gieSet ##[1:4] svcReq);
endmodule

// file: testbench/priority_interrupt_controller_tb_top.sv
// testbench: controller and core end joined by the interface, directed tests
// assumes the package, interface and both ends compiled first
`timescale 1ns/100ps
module priority_interrupt_controller_tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  srcPulse = 8'h00;
  logic [7:0]  srcEnable = 8'hff;
  logic [15:0] srcLevel = 16'h2940;
  logic        illegalTrap = 1'b0, primOscTrap = 1'b0, wdtOscTrap = 1'b0;
  logic        userGieSet = 1'b0, userGieClr = 1'b0, userDis = 1'b0, userTrap = 1'b0;
  logic        userPendWr = 1'b0, userAutoAck = 1'b0;
  logic [7:0]  userPendData = 8'hff;
  logic        svcTaken;
  logic [2:0]  svcTakenIdx;
  int          errorCnt = 0, comparisons = 0;
  pic_core_if cif ();
  pic_ctrl u_pic_ctrl (
    .core_clk    (core_clk),
    .rst         (rst),
    .srcPulse    (srcPulse),
    .srcEnable   (srcEnable),
    .srcLevel    (srcLevel),
    .illegalTrap (illegalTrap),
    .primOscTrap (primOscTrap),
    .wdtOscTrap  (wdtOscTrap),
    .cif         (cif)
  );
  pic_core_end u_pic_core_end (
    .core_clk     (core_clk),
    .rst          (rst),
    .userGieSet   (userGieSet),
    .userGieClr   (userGieClr),
    .userDis      (userDis),
    .userTrap     (userTrap),
    .userPendWr   (userPendWr),
    .userPendData (userPendData),
    .userAutoAck  (userAutoAck),
    .svcTaken     (svcTaken),
    .svcTakenIdx  (svcTakenIdx),
    .cif          (cif)
  );
  pic_chk u_pic_chk (.core_clk, .rst, .svcReq(cif.svcReq), .svcAck(cif.svcAck),
    .ackIdx(cif.ackIdx), .gieSet(cif.gieSet), .gieClr(cif.gieClr), .disInstr(cif.disInstr),
    .trapInstr(cif.trapInstr), .pendWrEn(cif.pendWrEn), .pendWrData(cif.pendWrData),
    .gieState(cif.gieState), .pendState(cif.pendState));
  initial forever #2 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic gieOn;
    userGieSet = 1'b1;
    tick(1);
    userGieSet = 1'b0;
    tick(4);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // levels: src3 and src4 at 1, src5 and src6 at 2; src3 is forced to the top
  initial begin
    tick(10);
    rst = 1'b0;
    chk(8'(cif.gieState), 8'h00);
    chk(cif.pendState, 8'h00);
    srcPulse = 8'h70;
    tick(1);
    srcPulse = 8'h00;
    tick(2);
    chk(cif.pendState, 8'h70);
    gieOn();
    chk(8'(cif.svcIdx), 8'h05);
    chk(8'(cif.svcReq), 8'h01);
    srcPulse = 8'h08;
    tick(1);
    srcPulse = 8'h00;
    tick(3);
    chk(8'(cif.svcIdx), 8'h03);
    $display("test ranking done");
    userAutoAck = 1'b1;
    tick(1);
    chk(8'(svcTaken), 8'h01);
    chk(8'(svcTakenIdx), 8'h03);
    tick(4);
    userAutoAck = 1'b0;
    chk(8'(svcTaken), 8'h00);
    chk(8'(cif.svcReq), 8'h00);
    chk(cif.pendState, 8'h70);
    chk(8'(cif.gieState), 8'h00);
    userPendWr = 1'b1;
    userPendData = 8'hdf;
    tick(1);
    userPendWr = 1'b0;
    tick(3);
    chk(cif.pendState, 8'h50);
    $display("test clearing done");
    srcEnable = 8'hbf;
    // each pass re-enables, then fires one clearing source
    for (int k = 0; k < 6; k++) begin
      gieOn();
      chk(8'(cif.gieState), 8'h01);
      chk(8'(cif.svcIdx), 8'h04);
      {userGieClr, userDis, userTrap, illegalTrap, primOscTrap, wdtOscTrap} = 6'(1 << k);
      tick(1);
      {userGieClr, userDis, userTrap, illegalTrap, primOscTrap, wdtOscTrap} = 6'h00;
      tick(3);
      chk(8'(cif.gieState), 8'h00);
      chk(8'(cif.svcReq), 8'h00);
    end
    $display("test global enable done");
    results();
  end
  initial begin
    tick(2000);
    errorCnt++;
    results();
  end
endmodule
